// ===== hdl/dma_transfer_controller.sv
// Transfer controller: staging FIFO, APB register file, channel engine
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module unit_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module dma_transfer_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] periph_req,
  input wire logic [3:0] external_transfer_request_pin,
  output logic bus_req,
  output logic bus_we,
  output logic [31:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_wide,
  output logic bus_io,
  output logic bus_lock,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  output logic [3:0] tc_irq
);
  logic [dma_pkg::CTL_BITS-1:0] ctl_reg [dma_pkg::NUM_CH];
  logic [31:0] src_reg [dma_pkg::NUM_CH];
  logic [31:0] dst_reg [dma_pkg::NUM_CH];
  logic [15:0] cnt_reg [dma_pkg::NUM_CH];
  logic [dma_pkg::BLOCK_W-1:0] blk_reg [dma_pkg::NUM_CH];
  logic [dma_pkg::COUNT_W-1:0] rem_reg [dma_pkg::NUM_CH];
  logic [3:0] pend_reg;
  logic [3:0] done_reg;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] periph_q_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  dma_pkg::eng_state_e state_reg;
  logic [dma_pkg::CH_W-1:0] cur_reg;
  logic [4:0] rd_left_reg;
  logic [4:0] wr_left_reg;
  logic [dma_pkg::BLOCK_W:0] blk_left_reg;
  logic bus_req_reg;
  logic bus_we_reg;
  logic [31:0] bus_addr_reg;
  logic [15:0] bus_wdata_reg;
  logic bus_wide_reg;
  logic bus_io_reg;
  logic bus_lock_reg;

  logic apb_setup;
  logic apb_wr;
  logic is_ch;
  logic [dma_pkg::CH_W-1:0] ch_sel;
  logic [4:0] ch_off;
  logic hit;
  logic [31:0] rd_val;
  logic [3:0] trig_set;
  logic [3:0] elig;
  logic any_elig;
  logic [dma_pkg::CH_W-1:0] pick;
  logic take;
  logic [1:0] cur_mode;
  logic cur_wide;
  logic [1:0] cur_dir;
  logic [dma_pkg::BLOCK_W:0] cur_blk_full;
  logic rd_ack;
  logic wr_ack;
  logic issue_rd;
  logic issue_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic finish;

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am,
                                            input logic wide);
    logic [31:0] inc;
    inc = wide ? 32'h0000_0002 : 32'h0000_0001;
    case (am)
      dma_pkg::AM_INC: step_addr = a + inc;
      dma_pkg::AM_DEC: step_addr = a - inc;
      default: step_addr = a;
    endcase
  endfunction

  function automatic logic [4:0] burst_len(input logic [1:0] mode,
                                           input logic [dma_pkg::BLOCK_W:0] blk,
                                           input logic [dma_pkg::COUNT_W-1:0] rem);
    logic [4:0] b;
    b = dma_pkg::BURST_MAX;
    if (mode != dma_pkg::MODE_BLOCK) begin
      b = 5'h01;
    end else begin
      if (blk < {6'h00, b}) begin
        b = blk[4:0];
      end
      if (rem < {12'h000, b}) begin
        b = rem[4:0];
      end
    end
    burst_len = b;
  endfunction

  // APB decode; answer comes on the second access cycle
  assign apb_setup = psel & penable & ~pready_reg;
  assign apb_wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign is_ch = ~paddr[7];
  assign ch_sel = paddr[6:5];
  assign ch_off = paddr[4:0];
  assign hit = is_ch ? (ch_off <= dma_pkg::OFF_STATUS && ch_off[1:0] == 2'h0)
                     : (paddr == dma_pkg::OFF_SWTRIG || paddr == dma_pkg::OFF_DONE);

  always_comb begin
    rd_val = 32'h0;
    if (is_ch) begin
      case (ch_off)
        dma_pkg::OFF_CTRL: rd_val = {20'h0, ctl_reg[ch_sel]};
        dma_pkg::OFF_SRC: rd_val = src_reg[ch_sel];
        dma_pkg::OFF_DST: rd_val = dst_reg[ch_sel];
        dma_pkg::OFF_COUNT: rd_val = {16'h0, cnt_reg[ch_sel]};
        dma_pkg::OFF_BLOCK: rd_val = {22'h0, blk_reg[ch_sel]};
        dma_pkg::OFF_STATUS: begin
          rd_val[dma_pkg::COUNT_W-1:0] = rem_reg[ch_sel];
          rd_val[dma_pkg::STS_PEND] = pend_reg[ch_sel];
          rd_val[dma_pkg::STS_BUSY] = (state_reg != dma_pkg::ST_IDLE) && (cur_reg == ch_sel);
          rd_val[dma_pkg::STS_DONE] = done_reg[ch_sel];
        end
        default: rd_val = 32'h0;
      endcase
    end else if (paddr == dma_pkg::OFF_DONE) begin
      rd_val = {28'h0, done_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup & ~hit;
      prdata_reg <= (apb_setup && !pwrite) ? rd_val : 32'h0;
    end
  end

  // Trigger sources; the pin goes through two flops before the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
      periph_q_reg <= 4'h0;
    end else begin
      pin_s1_reg <= external_transfer_request_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      periph_q_reg <= periph_req;
    end
  end

  always_comb begin
    for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
      trig_set[i] = ctl_reg[i][dma_pkg::CTL_EN] &
        (((ctl_reg[i][dma_pkg::CTL_TRIG +: 2] == dma_pkg::TRIG_PERIPH) &
          periph_req[i] & ~periph_q_reg[i]) |
         ((ctl_reg[i][dma_pkg::CTL_TRIG +: 2] == dma_pkg::TRIG_PIN) &
          pin_s2_reg[i] & ~pin_s3_reg[i]) |
         (apb_wr & ~is_ch & (paddr == dma_pkg::OFF_SWTRIG) & pwdata[i]));
      elig[i] = ctl_reg[i][dma_pkg::CTL_EN] & pend_reg[i] & (rem_reg[i] != '0);
    end
  end

  // Lowest channel number wins
  always_comb begin
    pick = '0;
    for (int i = dma_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = i[dma_pkg::CH_W-1:0];
      end
    end
  end

  assign any_elig = |elig;
  assign take = (state_reg == dma_pkg::ST_IDLE) & any_elig;
  assign cur_mode = ctl_reg[cur_reg][dma_pkg::CTL_MODE +: 2];
  assign cur_wide = ctl_reg[cur_reg][dma_pkg::CTL_WIDE];
  assign cur_dir = ctl_reg[cur_reg][dma_pkg::CTL_DIR +: 2];
  assign cur_blk_full = {1'b0, blk_reg[cur_reg]} + 11'h001;
  assign rd_ack = (state_reg == dma_pkg::ST_READ) & bus_req_reg & bus_ack;
  assign wr_ack = (state_reg == dma_pkg::ST_WRITE) & bus_req_reg & bus_ack;
  assign finish = (state_reg == dma_pkg::ST_NEXT) & (rem_reg[cur_reg] == '0);
  assign issue_rd = (state_reg == dma_pkg::ST_READ) & ~bus_req_reg & (rd_left_reg != 5'h00) &
                    fifo_in_ready;
  assign issue_wr = (state_reg == dma_pkg::ST_WRITE) & ~bus_req_reg & (wr_left_reg != 5'h00) &
                    fifo_out_valid;

  // A new trigger in the cycle a request is taken stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 4'h0;
    end else begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        pend_reg[i] <= trig_set[i] | (pend_reg[i] & ~(take && pick == i[dma_pkg::CH_W-1:0]));
      end
    end
  end

  // Completion flag: set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 4'h0;
    end else begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        done_reg[i] <= (finish && cur_reg == i[dma_pkg::CH_W-1:0]) |
          (done_reg[i] & ~(apb_wr & ~is_ch & (paddr == dma_pkg::OFF_DONE) & pwdata[i]));
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        ctl_reg[i] <= dma_pkg::CTL_RST[dma_pkg::CTL_BITS-1:0];
        cnt_reg[i] <= dma_pkg::COUNT_RST;
        blk_reg[i] <= dma_pkg::BLOCK_RST;
      end
    end else if (apb_wr && is_ch) begin
      case (ch_off)
        dma_pkg::OFF_CTRL: ctl_reg[ch_sel] <= pwdata[dma_pkg::CTL_BITS-1:0];
        dma_pkg::OFF_COUNT: cnt_reg[ch_sel] <= pwdata[15:0];
        dma_pkg::OFF_BLOCK: blk_reg[ch_sel] <= pwdata[dma_pkg::BLOCK_W-1:0];
        default: ;
      endcase
    end
  end

  // Live addresses and remaining count; engine updates land after software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        src_reg[i] <= dma_pkg::ADDR_RST;
        dst_reg[i] <= dma_pkg::ADDR_RST;
        rem_reg[i] <= '0;
      end
    end else begin
      if (apb_wr && is_ch && ch_off == dma_pkg::OFF_SRC) begin
        src_reg[ch_sel] <= pwdata;
      end
      if (apb_wr && is_ch && ch_off == dma_pkg::OFF_DST) begin
        dst_reg[ch_sel] <= pwdata;
      end
      if (apb_wr && is_ch && ch_off == dma_pkg::OFF_COUNT) begin
        rem_reg[ch_sel] <= {1'b0, pwdata[15:0]} + 17'h00001;
      end
      if (rd_ack) begin
        src_reg[cur_reg] <= step_addr(src_reg[cur_reg],
                                      ctl_reg[cur_reg][dma_pkg::CTL_SAM +: 2], cur_wide);
      end
      if (wr_ack) begin
        dst_reg[cur_reg] <= step_addr(dst_reg[cur_reg],
                                      ctl_reg[cur_reg][dma_pkg::CTL_DAM +: 2], cur_wide);
        rem_reg[cur_reg] <= rem_reg[cur_reg] - 17'h00001;
      end
    end
  end

  // Channel engine: bursts fill the FIFO, then drain it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dma_pkg::ST_IDLE;
      cur_reg <= '0;
      rd_left_reg <= 5'h00;
      wr_left_reg <= 5'h00;
      blk_left_reg <= '0;
    end else begin
      case (state_reg)
        dma_pkg::ST_IDLE: begin
          if (any_elig) begin
            cur_reg <= pick;
            blk_left_reg <= {1'b0, blk_reg[pick]} + 11'h001;
            rd_left_reg <= burst_len(ctl_reg[pick][dma_pkg::CTL_MODE +: 2],
                                     {1'b0, blk_reg[pick]} + 11'h001, rem_reg[pick]);
            wr_left_reg <= burst_len(ctl_reg[pick][dma_pkg::CTL_MODE +: 2],
                                     {1'b0, blk_reg[pick]} + 11'h001, rem_reg[pick]);
            state_reg <= dma_pkg::ST_READ;
          end
        end
        dma_pkg::ST_READ: begin
          if (rd_ack) begin
            rd_left_reg <= rd_left_reg - 5'h01;
            if (rd_left_reg == 5'h01) begin
              state_reg <= dma_pkg::ST_WRITE;
            end
          end
        end
        dma_pkg::ST_WRITE: begin
          if (wr_ack) begin
            wr_left_reg <= wr_left_reg - 5'h01;
            blk_left_reg <= blk_left_reg - 11'h001;
            if (wr_left_reg == 5'h01) begin
              state_reg <= dma_pkg::ST_NEXT;
            end
          end
        end
        dma_pkg::ST_NEXT: begin
          if (finish || cur_mode != dma_pkg::MODE_BLOCK) begin
            state_reg <= dma_pkg::ST_IDLE;
          end else if (blk_left_reg == '0) begin
            blk_left_reg <= cur_blk_full;
            rd_left_reg <= burst_len(cur_mode, cur_blk_full, rem_reg[cur_reg]);
            wr_left_reg <= burst_len(cur_mode, cur_blk_full, rem_reg[cur_reg]);
            state_reg <= dma_pkg::ST_READ;
          end else begin
            rd_left_reg <= burst_len(cur_mode, blk_left_reg, rem_reg[cur_reg]);
            wr_left_reg <= burst_len(cur_mode, blk_left_reg, rem_reg[cur_reg]);
            state_reg <= dma_pkg::ST_READ;
          end
        end
        default: state_reg <= dma_pkg::ST_IDLE;
      endcase
    end
  end

  // System bus master; one access outstanding, request held until ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_req_reg <= 1'b0;
      bus_we_reg <= 1'b0;
      bus_addr_reg <= 32'h0;
      bus_wdata_reg <= 16'h0;
      bus_wide_reg <= 1'b0;
      bus_io_reg <= 1'b0;
    end else if (bus_req_reg) begin
      if (bus_ack) begin
        bus_req_reg <= 1'b0;
      end
    end else if (issue_rd) begin
      bus_req_reg <= 1'b1;
      bus_we_reg <= 1'b0;
      bus_addr_reg <= src_reg[cur_reg];
      bus_wide_reg <= cur_wide;
      bus_io_reg <= (cur_dir == dma_pkg::DIR_IO_MEM);
    end else if (issue_wr) begin
      bus_req_reg <= 1'b1;
      bus_we_reg <= 1'b1;
      bus_addr_reg <= dst_reg[cur_reg];
      bus_wdata_reg <= cur_wide ? fifo_out_data : {8'h00, fifo_out_data[7:0]};
      bus_wide_reg <= cur_wide;
      bus_io_reg <= (cur_dir == dma_pkg::DIR_MEM_IO);
    end
  end

  // Step mode never holds the bus between units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_lock_reg <= 1'b0;
    end else begin
      bus_lock_reg <= (state_reg == dma_pkg::ST_READ || state_reg == dma_pkg::ST_WRITE) &&
                      cur_mode != dma_pkg::MODE_STEP;
    end
  end

  unit_fifo #(.W(dma_pkg::FIFO_W), .D(dma_pkg::FIFO_D)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rd_ack),
    .in_ready(fifo_in_ready),
    .in_data(bus_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(issue_wr),
    .out_data(fifo_out_data)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bus_req = bus_req_reg;
  assign bus_we = bus_we_reg;
  assign bus_addr = bus_addr_reg;
  assign bus_wdata = bus_wdata_reg;
  assign bus_wide = bus_wide_reg;
  assign bus_io = bus_io_reg;
  assign bus_lock = bus_lock_reg;
  assign tc_irq = done_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  single_one_unit_a: assert property (
    take && ctl_reg[pick][dma_pkg::CTL_MODE +: 2] == dma_pkg::MODE_SINGLE
    |=> rd_left_reg == 5'h01 && wr_left_reg == 5'h01)
    else $error("single mode burst is not one unit");
  step_release_a: assert property (
    state_reg == dma_pkg::ST_NEXT && cur_mode == dma_pkg::MODE_STEP
    |=> state_reg == dma_pkg::ST_IDLE ##1 !bus_lock_reg)
    else $error("single-step did not release the bus");
  block_continue_a: assert property (
    state_reg == dma_pkg::ST_NEXT && cur_mode == dma_pkg::MODE_BLOCK && !finish
    |=> state_reg == dma_pkg::ST_READ)
    else $error("block mode stopped before count end");
  narrow_step_a: assert property (
    rd_ack && !cur_wide && ctl_reg[cur_reg][dma_pkg::CTL_SAM +: 2] == dma_pkg::AM_INC
    |=> src_reg[cur_reg] == $past(src_reg[cur_reg]) + 32'h0000_0001)
    else $error("8-bit increment not by one");
  block_bound_a: assert property (
    state_reg == dma_pkg::ST_READ && cur_mode == dma_pkg::MODE_BLOCK
    |-> {6'h00, rd_left_reg} <= blk_left_reg)
    else $error("burst crosses block boundary");
  fixed_dst_a: assert property (
    wr_ack && ctl_reg[cur_reg][dma_pkg::CTL_DAM +: 2] == 2'h2
    |=> dst_reg[cur_reg] == $past(dst_reg[cur_reg]))
    else $error("fixed destination moved");
  pin_trigger_a: assert property (
    pin_s2_reg[1] && !pin_s3_reg[1] && ctl_reg[1][dma_pkg::CTL_EN] &&
    ctl_reg[1][dma_pkg::CTL_TRIG +: 2] == dma_pkg::TRIG_PIN
    |=> pend_reg[1])
    else $error("pin request lost");
  end_irq_a: assert property (
    finish |=> tc_irq[$past(cur_reg)] ##1 tc_irq[$past(cur_reg, 2)])
    else $error("transfer-end request not raised");
  io_space_a: assert property (
    issue_wr && cur_dir == dma_pkg::DIR_MEM_IO |=> bus_req_reg && bus_we_reg && bus_io_reg)
    else $error("I/O destination not flagged");
  wide_write_c: cover property (issue_wr && cur_wide);
  block_reload_c: cover property (state_reg == dma_pkg::ST_NEXT && blk_left_reg == '0 && !finish);
  all_done_c: cover property (done_reg == 4'hf);
  fifo_full_c: cover property (!fifo_in_ready);
endmodule

// ===== hdl/dma_pkg.sv
// Constants, field layout and types of the four-channel transfer controller
// Function
// - Single mode: one unit per accepted request
// - Single-step: one unit, release bus, wait for the next request
// - Block mode runs to count, up to 65536
// - Unit width per channel: 8 or 16 bits
// - Block size programmable from 1 to 1024
// - Source/destination increment, decrement or fixed
// - Four channels; peripheral, pin or software trigger
// - Transfer-end interrupt when count completes
package dma_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int COUNT_W = 17;
  localparam int BLOCK_W = 10;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;
  localparam logic [4:0] BURST_MAX = 5'h10;
  // Channel register offsets within a 0x20 window; channel = paddr[6:5]
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SRC = 5'h04;
  localparam logic [4:0] OFF_DST = 5'h08;
  localparam logic [4:0] OFF_COUNT = 5'h0c;
  localparam logic [4:0] OFF_BLOCK = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [7:0] OFF_SWTRIG = 8'h80;
  localparam logic [7:0] OFF_DONE = 8'h84;
  // Control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_WIDE = 3;
  localparam int CTL_SAM = 4;
  localparam int CTL_DAM = 6;
  localparam int CTL_DIR = 8;
  localparam int CTL_TRIG = 10;
  localparam int CTL_BITS = 12;
  // Status register fields
  localparam int STS_PEND = 24;
  localparam int STS_BUSY = 25;
  localparam int STS_DONE = 26;
  localparam logic [31:0] CTL_RST = 32'h0;
  localparam logic [31:0] ADDR_RST = 32'h0;
  localparam logic [15:0] COUNT_RST = 16'h0;
  localparam logic [BLOCK_W-1:0] BLOCK_RST = 10'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_STEP = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] DIR_MEM_MEM = 2'h0;
  localparam logic [1:0] DIR_MEM_IO = 2'h1;
  localparam logic [1:0] DIR_IO_MEM = 2'h2;
  localparam logic [1:0] TRIG_PERIPH = 2'h0;
  localparam logic [1:0] TRIG_PIN = 2'h1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_NEXT = 2'b11
  } eng_state_e;
endpackage

// ===== test/bus_memory_model.sv
// Behavioural memory and I/O space on the far side of the system bus
`timescale 1ns/1ps
module bus_memory_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] lag,
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  logic [1:0] wait_reg;
  // Data is a function of address; idle data toggles so stale values never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      wait_reg <= 2'h0;
      bus_rdata <= 16'h0;
    end else if (bus_req && !bus_ack && wait_reg == lag) begin
      bus_ack <= 1'b1;
      wait_reg <= 2'h0;
      bus_rdata <= {~bus_addr[7:0], bus_addr[7:0]};
    end else begin
      bus_ack <= 1'b0;
      wait_reg <= (bus_req && !bus_ack) ? wait_reg + 2'h1 : 2'h0;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule

// ===== test/dma_transfer_controller_tb.sv
// Self-checking bench of the four-channel transfer controller
`timescale 1ns/1ps
module dma_transfer_controller_tb;
  typedef struct {
    logic [1:0] ch, mode, sam, dam, dir, lag;
    logic wide;
    logic [15:0] cnt;
    logic [9:0] blk;
  } row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, ea;
  logic [3:0] periph_req, pin, tc_irq;
  logic bus_req, bus_we, bus_wide, bus_io, bus_lock, bus_ack, io_r, io_w, lock_seen, wide_seen;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [1:0] lag;
  logic [31:0] rd_a[$], wr_a[$];
  logic [15:0] wr_d[$];
  int failures, n_tests, cycles, n, per;
  row_s rows [4] = '{
    '{2'h0, dma_pkg::MODE_SINGLE, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 16'h1, 10'h0},
    '{2'h1, dma_pkg::MODE_STEP, 2'h1, 2'h2, 2'h1, 2'h1, 1'b1, 16'h2, 10'h0},
    '{2'h2, dma_pkg::MODE_BLOCK, 2'h2, 2'h0, 2'h2, 2'h3, 1'b1, 16'h4, 10'h1},
    '{2'h3, dma_pkg::MODE_BLOCK, 2'h0, 2'h1, 2'h0, 2'h2, 1'b0, 16'h13, 10'hf}};
  dma_transfer_controller dma_transfer_controller_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
    .external_transfer_request_pin(pin), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wide(bus_wide), .bus_io(bus_io),
    .bus_lock(bus_lock), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .tc_irq(tc_irq));
  bus_memory_model bus_memory_model_inst (.clk(pclk), .rst_n(presetn), .bus_req(bus_req),
    .bus_addr(bus_addr), .lag(lag), .bus_rdata(bus_rdata), .bus_ack(bus_ack));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Monitor records accepted accesses; a hang is cut short here
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
    if (bus_req && bus_ack && bus_we) begin
      wr_a.push_back(bus_addr);
      wr_d.push_back(bus_wdata);
      io_w |= bus_io;
    end
    if (bus_req && bus_ack && !bus_we) begin
      rd_a.push_back(bus_addr);
      io_r |= bus_io;
    end
    if (bus_req) wide_seen = bus_wide;
    lock_seen |= bus_lock;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task clr;
    rd_a.delete();
    wr_a.delete();
    wr_d.delete();
    {io_r, io_w, lock_seen} = 3'h0;
  endtask
  task await(input int k);
    for (int i = 0; i < 3000 && wr_a.size() < k; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
  endtask
  function automatic logic [31:0] at(logic [31:0] b, logic [1:0] am, logic w, int k);
    logic [31:0] s;
    s = w ? 32'(2 * k) : 32'(k);
    if (am == dma_pkg::AM_INC) return b + s;
    if (am == dma_pkg::AM_DEC) return b - s;
    return b;
  endfunction
  task run(input row_s r);
    clr();
    lag <= r.lag;
    apb(1'b1, {1'b0, r.ch, dma_pkg::OFF_SRC}, 32'h40);
    apb(1'b1, {1'b0, r.ch, dma_pkg::OFF_DST}, 32'h80);
    apb(1'b1, {1'b0, r.ch, dma_pkg::OFF_COUNT}, {16'h0, r.cnt});
    apb(1'b1, {1'b0, r.ch, dma_pkg::OFF_BLOCK}, {22'h0, r.blk});
    apb(1'b1, {1'b0, r.ch, dma_pkg::OFF_CTRL},
        {20'h0, 2'h2, r.dir, r.dam, r.sam, r.wide, r.mode, 1'b1});
    n = int'(r.cnt) + 1;
    per = (r.mode == dma_pkg::MODE_BLOCK) ? n : 1;
    for (int t = 0; t < n; t += per) begin
      apb(1'b1, dma_pkg::OFF_SWTRIG, 32'(4'h1 << r.ch));
      await(t + per);
      chk("units", 32'(t + per), 32'(wr_a.size()));
    end
    chk("tc_irq", 32'h1, 32'(tc_irq[r.ch]));
    for (int k = 0; k < n; k++) begin
      ea = at(32'h40, r.sam, r.wide, k);
      chk("src", ea, rd_a[k]);
      chk("dst", at(32'h80, r.dam, r.wide, k), wr_a[k]);
      chk("data", {16'h0, r.wide ? ~ea[7:0] : 8'h00, ea[7:0]}, 32'(wr_d[k]));
    end
    chk("wide", 32'(r.wide), 32'(wide_seen));
    chk("io", {30'h0, r.dir == dma_pkg::DIR_IO_MEM, r.dir == dma_pkg::DIR_MEM_IO},
        {30'h0, io_r, io_w});
    chk("lock", 32'(r.mode != dma_pkg::MODE_STEP), 32'(lock_seen));
    apb(1'b1, dma_pkg::OFF_DONE, 32'(4'h1 << r.ch));
    repeat (2) @(posedge pclk);
    chk("tc_clear", 32'h0, 32'(tc_irq[r.ch]));
    $display("test row ch %0d done", r.ch);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, periph_req, pin, lag} = 0;
    {paddr, pwdata} = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
    clr();
    // Count loaded first, so only the cleared enable can hold the trigger back
    apb(1'b1, {3'h0, dma_pkg::OFF_COUNT}, 32'h0);
    apb(1'b1, {3'h0, dma_pkg::OFF_CTRL}, 32'h0);
    apb(1'b1, dma_pkg::OFF_SWTRIG, 32'h1);
    await(1);
    chk("disabled", 32'h0, 32'(wr_a.size()));
    $display("test refusals done");
    // Peripheral request on ch0, then a pin request on ch1; a repeat on ch0 finds no count
    apb(1'b1, {3'h0, dma_pkg::OFF_CTRL}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      periph_req <= 4'h1;
      @(posedge pclk);
      periph_req <= 4'h0;
      await(1);
      chk("periph_units", 32'h1, 32'(wr_a.size()));
    end
    apb(1'b1, {3'h1, dma_pkg::OFF_COUNT}, 32'h0);
    apb(1'b1, {3'h1, dma_pkg::OFF_CTRL}, 32'h401);
    pin <= 4'h2;
    repeat (4) @(posedge pclk);
    pin <= 4'h0;
    await(2);
    chk("pin_units", 32'h2, 32'(wr_a.size()));
    chk("tc_both", 32'h3, 32'(tc_irq));
    $display("test triggers done");
    apb(1'b1, {3'h3, dma_pkg::OFF_COUNT}, 32'hffff);
    apb(1'b0, {3'h3, dma_pkg::OFF_STATUS}, 32'h0);
    chk("remaining_max", 32'h10000, rdat);
    apb(1'b1, {3'h3, dma_pkg::OFF_BLOCK}, 32'h3ff);
    apb(1'b0, {3'h3, dma_pkg::OFF_BLOCK}, 32'h0);
    chk("block_max", 32'h3ff, rdat);
    // Long block run cut by reset in mid-transfer
    apb(1'b1, dma_pkg::OFF_SWTRIG, 32'h8);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset_outputs", 32'h0, {26'h0, bus_req, bus_lock, tc_irq});
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, {3'h3, dma_pkg::OFF_CTRL}, 32'h0);
    chk("ctrl_reset", dma_pkg::CTL_RST, rdat);
    $display("test reset done");
    end_of_test();
  end
endmodule
